// File: ciexe_pkg.sv
// Constants shared by the instruction execution block.
// Assumes a 125 MHz core clock and an APB master with 32-bit data.
package ciexe_pkg;

  // ************************************************************
  // Opcode fields of the 14-bit instruction word
  // ************************************************************
  localparam logic [5:0] HI_LDW = 6'h30;
  localparam logic [5:0] HI_RETK = 6'h34;
  localparam logic [5:0] HI_SUBK = 6'h3c;
  localparam logic [5:0] HI_XORL = 6'h3a;
  localparam logic [5:0] HI_SUBB = 6'h3b;
  localparam logic [5:0] HI_ROTL = 6'h0d;
  localparam logic [5:0] HI_ROTR = 6'h0c;
  localparam logic [5:0] HI_SUBF = 6'h02;
  localparam logic [5:0] HI_SWAP = 6'h0e;
  localparam logic [5:0] HI_XORF = 6'h06;
  localparam logic [5:0] HI_MISC = 6'h00;
  localparam logic [6:0] HI7_PAGE = 7'h63;
  localparam logic [6:0] HI7_ISTK = 7'h7f;
  localparam logic [2:0] LO3_BANK = 3'h1;
  localparam logic [4:0] LO5_IST = 5'h03;
  localparam logic [7:0] LO_OPTION = 8'h62;
  localparam logic [7:0] LO_RESET = 8'h01;
  localparam logic [7:0] LO_RETI = 8'h09;
  localparam logic [7:0] LO_RETURN = 8'h08;
  localparam logic [7:0] LO_SLEEP = 8'h63;
  localparam logic [7:0] LO_DIR_A = 8'h65;
  localparam logic [7:0] LO_DIR_B = 8'h66;
  localparam logic [7:0] LO_DIR_C = 8'h67;
  localparam logic [1:0] MM_PREINC = 2'h0;
  localparam logic [1:0] MM_PREDEC = 2'h1;
  localparam logic [1:0] MM_POSTINC = 2'h2;
  localparam logic [1:0] MM_POSTDEC = 2'h3;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00000, OP_BANK = 5'b00001, OP_PAGE = 5'b00010,
    OP_LDW = 5'b00011, OP_STWF = 5'b00100, OP_IST = 5'b00101,
    OP_OPTION = 5'b00110, OP_RESET = 5'b00111, OP_RETI = 5'b01000,
    OP_RETURN = 5'b01001, OP_RETK = 5'b01010, OP_ROTL = 5'b01011,
    OP_ROTR = 5'b01100, OP_SUBK = 5'b01101, OP_SUBF = 5'b01110,
    OP_SUBB = 5'b01111, OP_SLEEP = 5'b10000, OP_SWAP = 5'b10001,
    OP_DIR = 5'b10010, OP_XORL = 5'b10011, OP_XORF = 5'b10100
  } ciexe_op_e;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] A_WORK = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_BANK = 8'h08;
  localparam logic [7:0] A_PAGE = 8'h0c;
  localparam logic [7:0] A_PTR0 = 8'h10;
  localparam logic [7:0] A_PTR1 = 8'h14;
  localparam logic [7:0] A_OPTION = 8'h18;
  localparam logic [7:0] A_INTCTL = 8'h1c;
  localparam logic [7:0] A_PWRCTL = 8'h20;
  localparam logic [7:0] A_DIR_A = 8'h24;
  localparam logic [7:0] A_DIR_B = 8'h28;
  localparam logic [7:0] A_DIR_C = 8'h2c;
  localparam logic [7:0] A_CTRL = 8'h30;

  // Status, interrupt enable and power control bit layout and reset values
  localparam int B_C = 0;
  localparam int B_DCY = 1;
  localparam int B_Z = 2;
  localparam int B_PDN = 3;
  localparam int B_TMO = 4;
  localparam int B_IEN = 7;
  localparam int B_RST = 2;
  localparam logic [4:0] RST_STATUS = 5'h18;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PWRCTL = 8'h04;
endpackage

// File: ciexe_core.sv
// Execution unit for literal, indirect, return, rotate, subtract,
// swap, direction and exclusive-OR instructions, with APB registers.
// Assumes instruction words arrive on core_clk and a stack feeds
// its top entry on stack_top.
`timescale 1ns/1ps

// Overview of operation
// - Bank literal load writes 5-bit literal into bank select, flags kept.
// - Page literal load writes 7-bit literal into PC high latch.
// - Working literal load puts 8-bit literal into W in one cycle.
// - Store working copies W into the addressed file register.
// - Indirect store picks pointer and pre/post inc/dec or signed offset.
// - Indirect window addresses redirect to the pointer's location.
// - Pointers are 16 bits and wrap on increment or decrement.
// - Pointer updates by indirect moves leave every status flag alone.
// - Option load copies W into the timer option register.
// - Software reset pulses a device reset and clears reset flag.
// - Returns pop stack into PC in two cycles; interrupt return enables.
// - Return with literal loads W and reloads PC, two cycles.
// - Destination bit 0 writes W, 1 writes the file register.
// - Rotate left through carry, only carry changes.
// - Rotate right through carry, old carry into bit 7.
// - Literal minus W into W; carries cleared on borrow; zero updated.
// - File minus W to destination; carries cleared on borrow; zero updated.
// - File minus W minus inverted carry; carries and zero updated.
// - Sleep clears watchdog, sets timeout, clears power-down, halts.
// - Nibble swap exchanges nibbles to destination, flags kept.
// - Direction load with operand 5, 6, 7 writes port A, B, C.
// - Exclusive OR with literal or file, only zero flag changes.
module ciexe_core #(
  parameter int MEM_AW = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  input wire logic [14:0] stack_top,
  output logic stack_pop,
  output logic pc_load,
  output logic [14:0] pc_value,
  input wire logic wake,
  output logic sleep_mode,
  output logic wdt_clear,
  output logic soft_reset,
  output logic [7:0] option_out,
  output logic [7:0] dir_a,
  output logic [7:0] dir_b,
  output logic [7:0] dir_c,
  output logic global_interrupt_enable
);

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] work;
  logic [4:0] status;
  logic [4:0] bank;
  logic [6:0] page;
  logic [15:0] ptr [2];
  logic [7:0] intctl;
  logic [7:0] pwrctl;
  logic run_en;
  logic [7:0] file_mem [2**MEM_AW];
  logic wake_s1, wake_s2, wake_s3;

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic ciexe_pkg::ciexe_op_e decode(input logic [13:0] i);
    ciexe_pkg::ciexe_op_e o;
    o = ciexe_pkg::OP_NONE;
    if (i[13:7] == ciexe_pkg::HI7_PAGE) o = ciexe_pkg::OP_PAGE;
    else if (i[13:7] == ciexe_pkg::HI7_ISTK) o = ciexe_pkg::OP_IST;
    else begin
      unique case (i[13:8])
        ciexe_pkg::HI_LDW: o = ciexe_pkg::OP_LDW;
        ciexe_pkg::HI_RETK: o = ciexe_pkg::OP_RETK;
        ciexe_pkg::HI_SUBK: o = ciexe_pkg::OP_SUBK;
        ciexe_pkg::HI_XORL: o = ciexe_pkg::OP_XORL;
        ciexe_pkg::HI_SUBB: o = ciexe_pkg::OP_SUBB;
        ciexe_pkg::HI_ROTL: o = ciexe_pkg::OP_ROTL;
        ciexe_pkg::HI_ROTR: o = ciexe_pkg::OP_ROTR;
        ciexe_pkg::HI_SUBF: o = ciexe_pkg::OP_SUBF;
        ciexe_pkg::HI_SWAP: o = ciexe_pkg::OP_SWAP;
        ciexe_pkg::HI_XORF: o = ciexe_pkg::OP_XORF;
        ciexe_pkg::HI_MISC: begin
          if (i[7]) o = ciexe_pkg::OP_STWF;
          else if (i[7:5] == ciexe_pkg::LO3_BANK) o = ciexe_pkg::OP_BANK;
          else if (i[7:3] == ciexe_pkg::LO5_IST) o = ciexe_pkg::OP_IST;
          else if (i[7:0] == ciexe_pkg::LO_OPTION) o = ciexe_pkg::OP_OPTION;
          else if (i[7:0] == ciexe_pkg::LO_RESET) o = ciexe_pkg::OP_RESET;
          else if (i[7:0] == ciexe_pkg::LO_RETI) o = ciexe_pkg::OP_RETI;
          else if (i[7:0] == ciexe_pkg::LO_RETURN) o = ciexe_pkg::OP_RETURN;
          else if (i[7:0] == ciexe_pkg::LO_SLEEP) o = ciexe_pkg::OP_SLEEP;
          else if (i[7:0] == ciexe_pkg::LO_DIR_A ||
                   i[7:0] == ciexe_pkg::LO_DIR_B ||
                   i[7:0] == ciexe_pkg::LO_DIR_C) o = ciexe_pkg::OP_DIR;
        end
        default: o = ciexe_pkg::OP_NONE;
      endcase
    end
    return o;
  endfunction

  // Returns {carry, digit carry, difference}; carry set means no borrow
  function automatic logic [9:0] sub8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  ciexe_pkg::ciexe_op_e op;
  logic fire, is_ret, dst_f, ind_sel, ptr_wr;
  logic [15:0] f_addr, ind_addr, next_ptr, sel_ptr;
  logic [7:0] fval, res, k8;
  logic wr_w, wr_f, upd_c, upd_dc, upd_z, n_c, n_dc;
  logic [1:0] mm;
  logic [9:0] sub_o;

  assign op = decode(instr_word);
  assign fire = instr_valid & instr_ready & run_en;
  assign is_ret = op == ciexe_pkg::OP_RETI || op == ciexe_pkg::OP_RETURN ||
                  op == ciexe_pkg::OP_RETK;
  assign k8 = instr_word[7:0];
  assign dst_f = instr_word[7];

  // Window addresses 0 and 1 stand for the location held in a pointer
  always_comb begin
    if (instr_word[6:1] == 6'h00) f_addr = ptr[instr_word[0]];
    else f_addr = {4'h0, bank, instr_word[6:0]};
  end

  assign fval = file_mem[f_addr[MEM_AW-1:0]];

  // Pointer select and addressing for the indirect store
  always_comb begin
    ind_sel = (instr_word[13:7] == ciexe_pkg::HI7_ISTK) ? instr_word[6]
                                                        : instr_word[2];
    sel_ptr = ptr[ind_sel];
    mm = instr_word[1:0];
    if (instr_word[13:7] == ciexe_pkg::HI7_ISTK) begin
      ind_addr = sel_ptr + {{10{instr_word[5]}}, instr_word[5:0]};
      next_ptr = sel_ptr;
    end else begin
      unique case (mm)
        ciexe_pkg::MM_PREINC: ind_addr = sel_ptr + 16'h0001;
        ciexe_pkg::MM_PREDEC: ind_addr = sel_ptr - 16'h0001;
        ciexe_pkg::MM_POSTINC: ind_addr = sel_ptr;
        ciexe_pkg::MM_POSTDEC: ind_addr = sel_ptr;
      endcase
      // Sixteen-bit arithmetic wraps both ways by itself
      next_ptr = mm[0] ? sel_ptr - 16'h0001 : sel_ptr + 16'h0001;
    end
    ptr_wr = fire && op == ciexe_pkg::OP_IST;
  end

  // ************************************************************
  // Result and flag datapath
  // ************************************************************
  always_comb begin
    res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    n_c = status[ciexe_pkg::B_C];
    n_dc = status[ciexe_pkg::B_DCY];
    sub_o = sub8(fval, work, 1'b1);
    unique case (op)
      ciexe_pkg::OP_LDW, ciexe_pkg::OP_RETK: begin
        res = k8;
        wr_w = 1'b1;
      end
      ciexe_pkg::OP_STWF, ciexe_pkg::OP_IST: begin
        res = work;
        wr_f = 1'b1;
      end
      ciexe_pkg::OP_ROTL: begin
        res = {fval[6:0], status[ciexe_pkg::B_C]};
        n_c = fval[7];
        upd_c = 1'b1;
      end
      ciexe_pkg::OP_ROTR: begin
        res = {status[ciexe_pkg::B_C], fval[7:1]};
        n_c = fval[0];
        upd_c = 1'b1;
      end
      ciexe_pkg::OP_SUBK, ciexe_pkg::OP_SUBF, ciexe_pkg::OP_SUBB: begin
        if (op == ciexe_pkg::OP_SUBK)
          sub_o = sub8(k8, work, 1'b1);
        else if (op == ciexe_pkg::OP_SUBB)
          sub_o = sub8(fval, work, status[ciexe_pkg::B_C]);
        {n_c, n_dc, res} = sub_o;
        upd_c = 1'b1;
        upd_dc = 1'b1;
        upd_z = 1'b1;
        wr_w = op == ciexe_pkg::OP_SUBK;
      end
      ciexe_pkg::OP_SWAP: res = {fval[3:0], fval[7:4]};
      ciexe_pkg::OP_XORL: begin
        res = work ^ k8;
        wr_w = 1'b1;
        upd_z = 1'b1;
      end
      ciexe_pkg::OP_XORF: begin
        res = work ^ fval;
        upd_z = 1'b1;
      end
      default: res = 8'h00;
    endcase
    // Destination bit picks W or the file register
    if (op == ciexe_pkg::OP_ROTL || op == ciexe_pkg::OP_ROTR ||
        op == ciexe_pkg::OP_SUBF || op == ciexe_pkg::OP_SUBB ||
        op == ciexe_pkg::OP_SWAP || op == ciexe_pkg::OP_XORF) begin
      wr_w = ~dst_f;
      wr_f = dst_f;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic apb_wr, apb_hit;
  logic [31:0] rd_mux;
  assign apb_wr = psel & penable & pready & pwrite;

  always_comb begin
    apb_hit = 1'b1;
    unique case (paddr)
      ciexe_pkg::A_WORK: rd_mux = {24'h0, work};
      ciexe_pkg::A_STATUS: rd_mux = {27'h0, status};
      ciexe_pkg::A_BANK: rd_mux = {27'h0, bank};
      ciexe_pkg::A_PAGE: rd_mux = {25'h0, page};
      ciexe_pkg::A_PTR0: rd_mux = {16'h0, ptr[0]};
      ciexe_pkg::A_PTR1: rd_mux = {16'h0, ptr[1]};
      ciexe_pkg::A_OPTION: rd_mux = {24'h0, option_out};
      ciexe_pkg::A_INTCTL: rd_mux = {24'h0, intctl};
      ciexe_pkg::A_PWRCTL: rd_mux = {24'h0, pwrctl};
      ciexe_pkg::A_DIR_A: rd_mux = {24'h0, dir_a};
      ciexe_pkg::A_DIR_B: rd_mux = {24'h0, dir_b};
      ciexe_pkg::A_DIR_C: rd_mux = {24'h0, dir_c};
      ciexe_pkg::A_CTRL: rd_mux = {30'h0, sleep_mode, run_en};
      default: begin
        rd_mux = 32'h0;
        apb_hit = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= psel & penable & ~pready & ~apb_hit;
    end
  end

  function automatic logic wr_at(input logic [7:0] a);
    return apb_wr && paddr == a;
  endfunction

  // ************************************************************
  // Architectural registers; instruction effects win over APB
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) work <= 8'h00;
    else if (fire && wr_w) work <= res;
    else if (wr_at(ciexe_pkg::A_WORK)) work <= pwdata[7:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) status <= ciexe_pkg::RST_STATUS;
    else if (fire && op == ciexe_pkg::OP_SLEEP) begin
      status[ciexe_pkg::B_TMO] <= 1'b1;
      status[ciexe_pkg::B_PDN] <= 1'b0;
    end else if (fire) begin
      // Pointer updates touch no flag bit here
      if (upd_c) status[ciexe_pkg::B_C] <= n_c;
      if (upd_dc) status[ciexe_pkg::B_DCY] <= n_dc;
      if (upd_z) status[ciexe_pkg::B_Z] <= res == 8'h00;
    end else if (wr_at(ciexe_pkg::A_STATUS)) status <= pwdata[4:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) bank <= 5'h00;
    else if (fire && op == ciexe_pkg::OP_BANK) bank <= instr_word[4:0];
    else if (wr_at(ciexe_pkg::A_BANK)) bank <= pwdata[4:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) page <= 7'h00;
    else if (fire && op == ciexe_pkg::OP_PAGE) page <= instr_word[6:0];
    else if (wr_at(ciexe_pkg::A_PAGE)) page <= pwdata[6:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr[0] <= 16'h0000;
      ptr[1] <= 16'h0000;
    end else if (ptr_wr) ptr[ind_sel] <= next_ptr;
    else if (wr_at(ciexe_pkg::A_PTR0)) ptr[0] <= pwdata[15:0];
    else if (wr_at(ciexe_pkg::A_PTR1)) ptr[1] <= pwdata[15:0];
  end

  // File memory has no reset; its contents are software's concern
  always_ff @(posedge core_clk) begin
    if (fire && wr_f) begin
      if (op == ciexe_pkg::OP_IST)
        file_mem[ind_addr[MEM_AW-1:0]] <= res;
      else
        file_mem[f_addr[MEM_AW-1:0]] <= res;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) option_out <= ciexe_pkg::RST_OPTION;
    else if (fire && op == ciexe_pkg::OP_OPTION) option_out <= work;
    else if (wr_at(ciexe_pkg::A_OPTION)) option_out <= pwdata[7:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir_a <= ciexe_pkg::RST_DIR;
      dir_b <= ciexe_pkg::RST_DIR;
      dir_c <= ciexe_pkg::RST_DIR;
    end else if (fire && op == ciexe_pkg::OP_DIR) begin
      if (instr_word[7:0] == ciexe_pkg::LO_DIR_A) dir_a <= work;
      if (instr_word[7:0] == ciexe_pkg::LO_DIR_B) dir_b <= work;
      if (instr_word[7:0] == ciexe_pkg::LO_DIR_C) dir_c <= work;
    end else begin
      if (wr_at(ciexe_pkg::A_DIR_A)) dir_a <= pwdata[7:0];
      if (wr_at(ciexe_pkg::A_DIR_B)) dir_b <= pwdata[7:0];
      if (wr_at(ciexe_pkg::A_DIR_C)) dir_c <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) intctl <= 8'h00;
    else if (fire && op == ciexe_pkg::OP_RETI)
      intctl[ciexe_pkg::B_IEN] <= 1'b1;
    else if (wr_at(ciexe_pkg::A_INTCTL)) intctl <= pwdata[7:0];
  end
  assign global_interrupt_enable = intctl[ciexe_pkg::B_IEN];

  always_ff @(posedge core_clk) begin
    if (rst) pwrctl <= ciexe_pkg::RST_PWRCTL;
    else if (fire && op == ciexe_pkg::OP_RESET)
      pwrctl[ciexe_pkg::B_RST] <= 1'b0;
    else if (wr_at(ciexe_pkg::A_PWRCTL)) pwrctl <= pwdata[7:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) run_en <= 1'b0;
    else if (wr_at(ciexe_pkg::A_CTRL)) run_en <= pwdata[0];
  end

  // ************************************************************
  // Flow control: returns, sleep, reset request
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end else begin
      wake_s1 <= wake;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  // Wake counts only once the two later stages agree
  logic next_sleep;
  always_comb begin
    next_sleep = sleep_mode;
    if (fire && op == ciexe_pkg::OP_SLEEP) next_sleep = 1'b1;
    else if (wake_s2 && wake_s3) next_sleep = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep_mode <= 1'b0;
      wdt_clear <= 1'b0;
      soft_reset <= 1'b0;
      instr_ready <= 1'b0;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= 15'h0000;
    end else begin
      sleep_mode <= next_sleep;
      wdt_clear <= fire && op == ciexe_pkg::OP_SLEEP;
      soft_reset <= fire && op == ciexe_pkg::OP_RESET;
      // The cycle after a return is the pipeline refill slot
      instr_ready <= run_en & ~(fire & is_ret) & ~next_sleep;
      stack_pop <= fire & is_ret;
      pc_load <= fire & is_ret;
      if (fire && is_ret) pc_value <= stack_top;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_bank_load: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_BANK |=> bank == $past(instr_word[4:0]) &&
      status == $past(status))
    else $error("bank literal not loaded");
  chk_page_load: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_PAGE |=> page == $past(instr_word[6:0]))
    else $error("page literal not loaded");
  chk_work_literal: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_LDW |=> work == $past(k8) &&
      status == $past(status))
    else $error("working literal not loaded");
  chk_ptr_flags: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_IST |=> status == $past(status) &&
      ptr[$past(ind_sel)] == $past(next_ptr))
    else $error("indirect store disturbed flags or pointer");
  chk_ret_two: assert property (@(posedge core_clk) disable iff (rst)
    fire && is_ret |=> !instr_ready && pc_load && stack_pop &&
      pc_value == $past(stack_top) ##1 !pc_load)
    else $error("return not two cycles");
  chk_ret_enable: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_RETI |=> global_interrupt_enable)
    else $error("interrupt return left enable clear");
  chk_sub_lit: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_SUBK |=>
      work == $past(k8 - work) &&
      status[ciexe_pkg::B_C] == ($past(work) <= $past(k8)))
    else $error("literal subtract wrong");
  chk_sleep_flags: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_SLEEP |=> wdt_clear && sleep_mode &&
      status[ciexe_pkg::B_TMO] && !status[ciexe_pkg::B_PDN] && !instr_ready)
    else $error("sleep entry wrong");
  chk_dir_load: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_DIR &&
      instr_word[7:0] == ciexe_pkg::LO_DIR_B |=> dir_b == $past(work))
    else $error("direction load wrong");
  chk_xor_zero: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ciexe_pkg::OP_XORL |=> work == $past(work ^ k8) &&
      status[ciexe_pkg::B_Z] == (work == 8'h00) &&
      status[ciexe_pkg::B_C] == $past(status[ciexe_pkg::B_C]))
    else $error("exclusive or wrong");

endmodule

// File: ciexe_prog_mem.sv
// Program memory model that feeds instruction words to the core.
// Assumes the bench fills mem and then raises fill_level.
`timescale 1ns/1ps
module ciexe_prog_mem #(
  parameter logic [14:0] TOP = 15'h2a5c
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] fill_level,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [13:0] instr_word,
  output logic [14:0] stack_top
);
  // ****
  // Word queue
  // ****
  logic [13:0] mem [0:63];
  logic [5:0] rd_ptr;
  initial foreach (mem[i]) mem[i] = 14'h0000;
  assign instr_valid = rd_ptr != fill_level;
  // Idle bus shows the inverse of the last word, so no stale copy helps
  assign instr_word = instr_valid ? mem[rd_ptr] : ~mem[rd_ptr - 6'h01];
  assign stack_top = TOP;
  always_ff @(posedge core_clk) begin
    if (rst)
      rd_ptr <= 6'h00;
    else if (instr_valid && instr_ready)
      rd_ptr <= rd_ptr + 6'h01;
  end
endmodule

// File: tb_top.sv
// Bench for the execution core, fed by the program memory model.
// Assumes the package register map; registers are seen over APB.
`timescale 1ns/1ps
module tb_top;
  // ****
  // Harness
  // ****
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic wake = 0, pready, pslverr, instr_valid, instr_ready, stack_pop;
  logic pc_load, sleep_mode, wdt_clear, soft_reset, global_interrupt_enable, se;
  logic [7:0] paddr = 8'h00, option_out, dir_a, dir_b, dir_c;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [13:0] instr_word, prog[$];
  logic [14:0] stack_top, pc_value;
  logic [5:0] fill = 6'h00;
  int err_total = 0, samples_checked = 0, cyc = 0, pops = 0, wdts = 0;
  int srs = 0;
  ciexe_core ciexe_core_inst (.core_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .instr_valid,
    .instr_word, .instr_ready, .stack_top, .stack_pop, .pc_load,
    .pc_value, .wake, .sleep_mode, .wdt_clear, .soft_reset,
    .option_out, .dir_a, .dir_b, .dir_c, .global_interrupt_enable);
  ciexe_prog_mem ciexe_prog_mem_inst (.core_clk, .rst, .fill_level(fill),
    .instr_ready, .instr_valid, .instr_word, .stack_top);
  always #4 core_clk = ~core_clk;
  // Counting cycles, not edges, so a stuck pulse shows as a count above 1
  always @(posedge core_clk) begin
    cyc++;
    if (stack_pop === 1'b1) pops++;
    if (wdt_clear === 1'b1) wdts++;
    if (soft_reset === 1'b1) srs++;
    if (cyc == 20000) begin
      err_total++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  // Returns take two cycles, so the wait ends with slack
  task automatic go;
    int n;
    n = 0;
    @(posedge core_clk);
    foreach (prog[i]) ciexe_prog_mem_inst.mem[fill + 6'(i)] = prog[i];
    fill <= fill + 6'(prog.size());
    @(posedge core_clk);
    while (instr_valid === 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (instr_valid === 1'b1) err_total++;
    repeat (3) @(posedge core_clk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd(8'h04, 32'h18);
    rd(8'h20, 32'h04);
    chk(32'(option_out), 32'hff);
    rd(8'hfc, 32'h0);
    chk(32'(se), 32'h1);
    apb(1'b1, 8'h30, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_lits;
    prog = '{14'h003f, 14'h31ff, 14'h305a};
    go;
    rd(8'h08, 32'h1f);
    rd(8'h0c, 32'h7f);
    rd(8'h00, 32'h5a);
    rd(8'h04, 32'h18);
    $display("test lits done");
  endtask
  task automatic t_sub;
    prog = '{14'h3003, 14'h3c02};
    go;
    rd(8'h00, 32'hff);
    rd(8'h04, 32'h18);
    prog = '{14'h3002, 14'h3c02, 14'h3010, 14'h00a0};
    go;
    rd(8'h04, 32'h1f);
    prog = '{14'h3001, 14'h3b20};
    go;
    rd(8'h00, 32'h0f);
    rd(8'h04, 32'h19);
    prog = '{14'h02a0, 14'h0620};
    go;
    rd(8'h00, 32'h0e);
    $display("test sub done");
  endtask
  task automatic t_shift;
    prog = '{14'h00a1, 14'h0da1, 14'h0c21, 14'h0e21, 14'h3aff, 14'h0621};
    go;
    rd(8'h00, 32'h33);
    rd(8'h04, 32'h19);
    prog = '{14'h3a33};
    go;
    rd(8'h04, 32'h1d);
    $display("test shift done");
  endtask
  task automatic t_ind;
    apb(1'b1, 8'h10, 32'hffff);
    apb(1'b1, 8'h14, 32'h0030);
    prog = '{14'h30a5, 14'h0018, 14'h001b, 14'h001c, 14'h3fc5};
    go;
    rd(8'h10, 32'hffff);
    rd(8'h14, 32'h31);
    rd(8'h04, 32'h1d);
    prog = '{14'h3a0f, 14'h0601};
    go;
    rd(8'h00, 32'h0f);
    $display("test indirect done");
  endtask
  task automatic t_ctl;
    prog = '{14'h304f, 14'h0062, 14'h0065, 14'h0066, 14'h0067, 14'h0009,
             14'h3477, 14'h0008};
    go;
    chk(32'(option_out), 32'h4f);
    chk({dir_a, dir_b, dir_c}, 32'h4f4f4f);
    chk(32'(global_interrupt_enable), 32'h1);
    chk(32'(pc_value), 32'h2a5c);
    chk(pops, 3);
    rd(8'h00, 32'h77);
    $display("test control done");
  endtask
  task automatic t_sleep;
    int n;
    n = 0;
    prog = '{14'h0001};
    go;
    chk(srs, 1);
    rd(8'h20, 32'h0);
    prog = '{14'h0063};
    go;
    chk(wdts, 32'h1);
    chk(32'(sleep_mode), 32'h1);
    rd(8'h04, 32'h11);
    wake <= 1'b1;
    while (sleep_mode === 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    wake <= 1'b0;
    chk(32'(sleep_mode), 32'h0);
    $display("test sleep done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_lits;
    t_sub;
    t_shift;
    t_ind;
    t_ctl;
    t_sleep;
    stop_test;
  end
endmodule
